// [rtl/delay_and_irq_latch_regs.v]
// group delay control and event status-mode latching register bank
`timescale 1ns/1ps
`include "delay_and_irq_latch_regs.vh"

module delay_and_irq_latch_regs
(
    core_clk,
    nrst,
    regAddr,
    regWrData,
    regWrite,
    regRead,
    regRdData,
    regRdValid,
    calibration_pass_flag,
    calibration_fail_flag,
    converter_pll_lost_flag,
    converter_pll_locked_flag,
    serial_pll_lost_flag,
    irqN,
    output_pair_delay_code,
    protectControl,
    chanInEarly,
    chanInLate,
    chanOutEarly,
    chanOutLate
);
    input  wire                        core_clk;
    input  wire                        nrst;
    input  wire [`ADDR_W-1:0]          regAddr;
    input  wire [`DATA_W-1:0]          regWrData;
    input  wire                        regWrite;
    input  wire                        regRead;
    output reg  [`DATA_W-1:0]          regRdData;
    output reg                         regRdValid;
    input  wire                        calibration_pass_flag;
    input  wire                        calibration_fail_flag;
    input  wire                        converter_pll_lost_flag;
    input  wire                        converter_pll_locked_flag;
    input  wire                        serial_pll_lost_flag;
    output reg                         irqN;
    output wire [`DELAY_CODE_W-1:0]    output_pair_delay_code;
    output wire [`DATA_W-1:0]          protectControl;
    input  wire [2*`SAMPLE_W-1:0]      chanInEarly;
    input  wire [2*`SAMPLE_W-1:0]      chanInLate;
    output wire [2*`SAMPLE_W-1:0]      chanOutEarly;
    output wire [2*`SAMPLE_W-1:0]      chanOutLate;

    ////////////////////////////////////////////////////////////////////////
    // register state
    reg  [`DELAY_CODE_W-1:0]  delayCode_reg;
    reg  [`DELAY_CODE_W-1:0]  delayCode_next;
    reg  [`EV_W-1:0]          latchMode_reg;
    reg  [`EV_W-1:0]          latchMode_next;
    reg  [`DATA_W-1:0]        protect_reg;
    reg  [`DATA_W-1:0]        protect_next;
    reg  [`EV_W-1:0]          eventLatched_reg;
    reg  [`EV_W-1:0]          eventLatched_next;
    reg  [`EV_W-1:0]          flagPrev_reg;
    reg  [`DATA_W-1:0]        rdData_next;
    reg                       irqN_next;

    // live flags gathered in their register bit order, offset down by EV_LSB
    wire [`EV_W-1:0]          flagLive;
    wire [`EV_W-1:0]          flagRise;
    wire [`EV_W-1:0]          eventShown;
    wire [`EV_W-1:0]          clearMask;
    wire                      wrDelay;
    wire                      wrMode;
    wire                      wrProtect;
    wire                      wrStatus;

    ////////////////////////////////////////////////////////////////////////
    // address decode for writes
    assign wrDelay   = regWrite && (regAddr == `OFS_GROUP_DELAY);
    assign wrMode    = regWrite && (regAddr == `OFS_LATCH_MODE_0);
    assign wrProtect = regWrite && (regAddr == `OFS_POWER_PROTECT);
    assign wrStatus  = regWrite && (regAddr == `OFS_EVENT_STATUS_0);

    // event vector, msb is calibration pass
    assign flagLive = {calibration_pass_flag,
                       calibration_fail_flag,
                       converter_pll_lost_flag,
                       converter_pll_locked_flag,
                       serial_pll_lost_flag};

    // rising edge of each live event
    assign flagRise = flagLive & ~flagPrev_reg;

    // write one to clear on the status register
    assign clearMask = wrStatus ? regWrData[`EV_MSB:`EV_LSB] : 5'h00;

    // status bit shows latch in latch mode, live level otherwise
    assign eventShown = (latchMode_reg & eventLatched_reg) |
                        (~latchMode_reg & flagLive);

    ////////////////////////////////////////////////////////////////////////
    // control register next values
    always @*
    begin
        delayCode_next = delayCode_reg;
        latchMode_next = latchMode_reg;
        protect_next   = protect_reg;
        if (wrDelay)
            delayCode_next = regWrData[`DELAY_CODE_MSB:`DELAY_CODE_LSB];
        if (wrMode)
            latchMode_next = regWrData[`EV_MSB:`EV_LSB];
        if (wrProtect)
            protect_next = regWrData & `PROTECT_RW_MASK;
    end

    // control registers
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            delayCode_reg <= `DELAY_CODE_RESET;
            latchMode_reg <= `LATCH_MODE_RESET;
            protect_reg   <= `PROTECT_RESET;
        end
        else
        begin
            delayCode_reg <= delayCode_next;
            latchMode_reg <= latchMode_next;
            protect_reg   <= protect_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event latch next value; a new rise beats a clear in the same cycle
    always @*
    begin
        eventLatched_next = eventLatched_reg & ~clearMask;
        eventLatched_next[`EV_CAL_PASS-`EV_LSB] =
            eventLatched_next[`EV_CAL_PASS-`EV_LSB] |
            (flagRise[`EV_CAL_PASS-`EV_LSB] &
             latchMode_reg[`EV_CAL_PASS-`EV_LSB]);
        eventLatched_next[`EV_CAL_FAIL-`EV_LSB] =
            eventLatched_next[`EV_CAL_FAIL-`EV_LSB] |
            (flagRise[`EV_CAL_FAIL-`EV_LSB] &
             latchMode_reg[`EV_CAL_FAIL-`EV_LSB]);
        eventLatched_next[`EV_CONV_PLL_LOST-`EV_LSB] =
            eventLatched_next[`EV_CONV_PLL_LOST-`EV_LSB] |
            (flagRise[`EV_CONV_PLL_LOST-`EV_LSB] &
             latchMode_reg[`EV_CONV_PLL_LOST-`EV_LSB]);
        eventLatched_next[`EV_CONV_PLL_LOCKED-`EV_LSB] =
            eventLatched_next[`EV_CONV_PLL_LOCKED-`EV_LSB] |
            (flagRise[`EV_CONV_PLL_LOCKED-`EV_LSB] &
             latchMode_reg[`EV_CONV_PLL_LOCKED-`EV_LSB]);
        eventLatched_next[`EV_SERIAL_PLL_LOST-`EV_LSB] =
            eventLatched_next[`EV_SERIAL_PLL_LOST-`EV_LSB] |
            (flagRise[`EV_SERIAL_PLL_LOST-`EV_LSB] &
             latchMode_reg[`EV_SERIAL_PLL_LOST-`EV_LSB]);
        // a latch is never kept for an event in live mode
        eventLatched_next = eventLatched_next & latchMode_reg;
    end

    // event latches and previous level for edge detect
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            eventLatched_reg <= 5'h00;
            flagPrev_reg     <= 5'h00;
        end
        else
        begin
            eventLatched_reg <= eventLatched_next;
            flagPrev_reg     <= flagLive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt low while any latched event remains
    always @*
    begin
        irqN_next = ~(|(eventLatched_next & latchMode_next));
    end

    // interrupt output flop
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irqN <= 1'b1;
        else
            irqN <= irqN_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, reserved bits and unmapped offsets read zero
    always @*
    begin
        rdData_next = 8'h00;
        case (regAddr)
            `OFS_GROUP_DELAY:
                rdData_next = {4'h0, delayCode_reg};
            `OFS_LATCH_MODE_0:
                rdData_next = {latchMode_reg, 3'h0};
            `OFS_POWER_PROTECT:
                rdData_next = protect_reg;
            `OFS_EVENT_STATUS_0:
                rdData_next = {eventShown, 3'h0};
            default:
                rdData_next = 8'h00;
        endcase
    end

    // read data and valid, one cycle after the read strobe
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            if (regRead)
                regRdData <= rdData_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register values driven out straight from their flops
    assign output_pair_delay_code = delayCode_reg;
    assign protectControl         = protect_reg;

    // both channels of the pair move by the same code
    pair_delay_line uDelay
    (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .delayCode    (delayCode_reg),
        .chanInEarly  (chanInEarly),
        .chanInLate   (chanInLate),
        .chanOutEarly (chanOutEarly),
        .chanOutLate  (chanOutLate)
    );

endmodule // delay_and_irq_latch_regs

// [rtl/delay_and_irq_latch_regs.vh]
// register offsets, field positions and reset values of the delay/event bank
`ifndef DELAY_AND_IRQ_LATCH_REGS_VH
`define DELAY_AND_IRQ_LATCH_REGS_VH

// register interface widths
`define ADDR_W              12
`define DATA_W              8

// register offsets
`define OFS_POWER_PROTECT   12'h013
`define OFS_GROUP_DELAY     12'h014
`define OFS_LATCH_MODE_0    12'h01f
`define OFS_EVENT_STATUS_0  12'h0f0

// output_group_delay fields
`define DELAY_CODE_MSB      3
`define DELAY_CODE_LSB      0
`define DELAY_CODE_W        4
`define DELAY_CODE_RESET    4'h8

// event bit positions in latch mode and status registers
`define EV_CAL_PASS         7
`define EV_CAL_FAIL         6
`define EV_CONV_PLL_LOST    5
`define EV_CONV_PLL_LOCKED  4
`define EV_SERIAL_PLL_LOST  3
`define EV_MSB              7
`define EV_LSB              3
`define EV_W                5
`define LATCH_MODE_RESET    5'h00

// power_protect_control writable bits and reset value
`define PROTECT_RW_MASK     8'h6c
`define PROTECT_RESET       8'h20

// delay line geometry: two half-period samples per converter clock
`define SAMPLE_W            16
`define HALF_PER_CLK        2
`define DELAY_STEPS         16
`define HIST_DEPTH          18

`endif

// [rtl/pair_delay_line.v]
// half-period step delay line shared by both channels of an output pair
`timescale 1ns/1ps
`include "delay_and_irq_latch_regs.vh"

module pair_delay_line
(
    core_clk,
    nrst,
    delayCode,
    chanInEarly,
    chanInLate,
    chanOutEarly,
    chanOutLate
);
    input  wire                        core_clk;
    input  wire                        nrst;
    input  wire [`DELAY_CODE_W-1:0]    delayCode;
    input  wire [2*`SAMPLE_W-1:0]      chanInEarly;
    input  wire [2*`SAMPLE_W-1:0]      chanInLate;
    output reg  [2*`SAMPLE_W-1:0]      chanOutEarly;
    output reg  [2*`SAMPLE_W-1:0]      chanOutLate;

    ////////////////////////////////////////////////////////////////////////
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : gChan
            // history of half-period samples, index 0 is the newest
            reg  [`SAMPLE_W-1:0] hist_reg [0:`HIST_DEPTH-1];
            wire [4:0]           tapLate;
            wire [4:0]           tapEarly;
            integer              k;

            assign tapLate  = {1'b0, delayCode};
            assign tapEarly = {1'b0, delayCode} + 5'h01;

            // shift two half-period samples in per clock
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    for (k = 0; k < `HIST_DEPTH; k = k + 1)
                        hist_reg[k] <= 16'h0000;
                end
                else
                begin
                    for (k = `HIST_DEPTH-1; k >= `HALF_PER_CLK; k = k - 1)
                        hist_reg[k] <= hist_reg[k-`HALF_PER_CLK];
                    hist_reg[0] <= chanInLate[ch*`SAMPLE_W +: `SAMPLE_W];
                    hist_reg[1] <= chanInEarly[ch*`SAMPLE_W +: `SAMPLE_W];
                end
            end

            // one code step moves both channels by one half period
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    chanOutEarly[ch*`SAMPLE_W +: `SAMPLE_W] <= 16'h0000;
                    chanOutLate[ch*`SAMPLE_W +: `SAMPLE_W]  <= 16'h0000;
                end
                else
                begin
                    chanOutEarly[ch*`SAMPLE_W +: `SAMPLE_W] <=
                        hist_reg[tapEarly];
                    chanOutLate[ch*`SAMPLE_W +: `SAMPLE_W]  <=
                        hist_reg[tapLate];
                end
            end
        end
    endgenerate

endmodule // pair_delay_line

// [test/delay_and_irq_latch_regs_asserts.sv]
// port assertions for the delay and event latch register bank
`timescale 1ns/1ps
`include "delay_and_irq_latch_regs.vh"

module delay_and_irq_latch_regs_asserts
(
    input wire                     core_clk,
    input wire                     nrst,
    input wire [`ADDR_W-1:0]       regAddr,
    input wire [`DATA_W-1:0]       regWrData,
    input wire                     regWrite,
    input wire                     regRead,
    input wire [`DATA_W-1:0]       regRdData,
    input wire                     regRdValid,
    input wire                     calibration_pass_flag,
    input wire                     calibration_fail_flag,
    input wire                     converter_pll_lost_flag,
    input wire                     converter_pll_locked_flag,
    input wire                     serial_pll_lost_flag,
    input wire                     irqN,
    input wire [`DELAY_CODE_W-1:0] output_pair_delay_code
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // event flags in status bit order, delay register write strobe
    wire [4:0] ev = {calibration_pass_flag, calibration_fail_flag,
        converter_pll_lost_flag, converter_pll_locked_flag,
        serial_pll_lost_flag};
    wire wrDly = regWrite && regAddr == `OFS_GROUP_DELAY;

    ////////////////////////////////////////////////////////////////////
    a_read_gets_valid: assert property (regRead |=> regRdValid)
        else $error("read strobe gave no valid pulse");
    a_valid_needs_read: assert property (regRdValid |-> $past(regRead))
        else $error("read valid without a read");
    a_rd_data_hold: assert property (!regRead |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_code_write: assert property (wrDly |=>
        output_pair_delay_code == $past(regWrData[3:0]))
        else $error("delay code did not take written value");
    a_code_hold: assert property (!wrDly |=>
        $stable(output_pair_delay_code))
        else $error("delay code changed without a write");
    a_code_readback: assert property (regRead && !regWrite &&
        regAddr == `OFS_GROUP_DELAY |=>
        regRdData == {4'h0, $past(output_pair_delay_code)})
        else $error("delay register read back wrong");
    a_irq_needs_rise: assert property ($fell(irqN) |->
        |($past(ev) & ~$past(ev, 2)))
        else $error("irq asserted with no event rise");
    a_irq_release_write: assert property ($rose(irqN) |->
        $past(regWrite) || $past(regWrite, 2))
        else $error("irq released without a clearing write");
    a_irq_hold_low: assert property (!irqN && !regWrite &&
        !$past(regWrite) |=> !irqN)
        else $error("irq released on its own");

    // main scenarios reached
    c_irq_set: cover property ($fell(irqN));
    c_irq_clear: cover property ($rose(irqN));
    c_code_write: cover property (wrDly);
endmodule // delay_and_irq_latch_regs_asserts

bind delay_and_irq_latch_regs delay_and_irq_latch_regs_asserts i_chk
(
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .regRdValid(regRdValid), .irqN(irqN),
    .calibration_pass_flag(calibration_pass_flag),
    .calibration_fail_flag(calibration_fail_flag),
    .converter_pll_lost_flag(converter_pll_lost_flag),
    .converter_pll_locked_flag(converter_pll_locked_flag),
    .serial_pll_lost_flag(serial_pll_lost_flag),
    .output_pair_delay_code(output_pair_delay_code)
);

// [test/tb.sv]
// self-checking bench for the delay and event latch register bank
`timescale 1ns/1ps
`include "delay_and_irq_latch_regs.vh"
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", n, e, g); \
    end end

module tb;
    reg               core_clk;
    reg               nrst;
    reg [11:0]        regAddr;
    reg [7:0]         regWrData;
    reg               regWrite;
    reg               regRead;
    reg [4:0]         ev;
    reg [31:0]        inE;
    reg [31:0]        inL;
    reg               chk;
    reg [7:0]         d;
    reg [31:0]        hE [0:9];
    reg [31:0]        hL [0:9];
    wire [7:0]        regRdData;
    wire              regRdValid;
    wire              irqN;
    wire [3:0]        code;
    wire [7:0]        prot;
    wire [31:0]       outE;
    wire [31:0]       outL;
    int               miscompares;
    int               totalChecks;
    int               i;
    int               j;
    int               k;
    // unmapped, status, mode, delay, protect and their reset reads
    wire [59:0] adrs = {12'h0aa, `OFS_EVENT_STATUS_0, `OFS_LATCH_MODE_0,
        `OFS_GROUP_DELAY, `OFS_POWER_PROTECT};
    wire [39:0] rstv = {28'h0, `DELAY_CODE_RESET, `PROTECT_RESET};
    wire [19:0] cds = 20'hf8710;

    delay_and_irq_latch_regs i_delay_and_irq_latch_regs
    (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .calibration_pass_flag(ev[4]), .calibration_fail_flag(ev[3]),
        .converter_pll_lost_flag(ev[2]), .converter_pll_locked_flag(ev[1]),
        .serial_pll_lost_flag(ev[0]), .irqN(irqN),
        .output_pair_delay_code(code), .protectControl(prot),
        .chanInEarly(inE), .chanInLate(inL),
        .chanOutEarly(outE), .chanOutLate(outL)
    );

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // readback value: writable bits only
    function [7:0] expRd(input [11:0] a, input [7:0] v);
        case (a)
            `OFS_POWER_PROTECT: expRd = v & `PROTECT_RW_MASK;
            `OFS_GROUP_DELAY:   expRd = v & 8'h0f;
            `OFS_LATCH_MODE_0:  expRd = v & 8'hf8;
            default:            expRd = 8'h00;
        endcase
    endfunction

    // random sample streams, history, late and early outputs against history
    always @(posedge core_clk)
    begin
        // output seen here left its flop one edge ago, from two-edge-old history
        k = 1 + code / 2;
        if (chk)
        begin
            `CHK("late out", code[0] ? hE[k] : hL[k], outL)
            `CHK("early out", code[0] ? hL[k + 1] : hE[k], outE)
        end
        for (j = 9; j > 0; j--)
        begin
            hE[j] = hE[j - 1];
            hL[j] = hL[j - 1];
        end
        hE[0] = inE;
        hL[0] = inL;
        inE <= $urandom;
        inL <= $urandom;
    end

    ////////////////////////////////////////////////////////////////////
    task wr(input [11:0] a, input [7:0] v);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    end
    endtask

    task rd(input [11:0] a, input [7:0] e);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        `CHK("read valid", 1'b1, regRdValid)
        `CHK("read data", e, regRdData)
    end
    endtask

    task pulse(input [4:0] m);
    begin
        @(posedge core_clk);
        ev <= m;
        repeat ($urandom % 3) @(posedge core_clk);
        @(posedge core_clk);
        ev <= 5'h00;
    end
    endtask

    task irqIs(input e);
    begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("irq", e, irqN)
    end
    endtask

    task finish_test;
    begin
        $display("checks %0d miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // watchdog against a hang
    initial
    begin
        #200000;
        miscompares++;
        finish_test;
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {nrst, regAddr, regWrData, regWrite, regRead, ev} = '0;
        {inE, inL, chk, miscompares, totalChecks} = '0;
        void'($urandom(88330));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        for (i = 0; i < 5; i++)
        begin
            rd(adrs[12*i +: 12], rstv[8*i +: 8]);
            wr(adrs[12*i +: 12], 8'hff);
            rd(adrs[12*i +: 12], expRd(adrs[12*i +: 12], 8'hff));
            d = $urandom;
            wr(adrs[12*i +: 12], d);
            rd(adrs[12*i +: 12], expRd(adrs[12*i +: 12], d));
        end
        wr(`OFS_POWER_PROTECT, 8'hff);
        @(negedge core_clk);
        `CHK("protect", `PROTECT_RW_MASK, prot)
        $display("done registers");
        for (i = 0; i < 6; i++)
        begin
            d = (i < 5) ? cds[4*i +: 4] : $urandom % 16;
            wr(`OFS_GROUP_DELAY, {4'($urandom), d[3:0]});
            rd(`OFS_GROUP_DELAY, {4'h0, d[3:0]});
            repeat (12) @(posedge core_clk);
            chk <= 1'b1;
            repeat (8) @(posedge core_clk);
            chk <= 1'b0;
        end
        $display("done delay");
        for (i = 0; i < 5; i++)
        begin
            d = 8'h08 << i;
            wr(`OFS_LATCH_MODE_0, d);
            pulse(5'h01 << i);
            irqIs(1'b0);
            rd(`OFS_EVENT_STATUS_0, d);
            wr(`OFS_EVENT_STATUS_0, d);
            irqIs(1'b1);
            rd(`OFS_EVENT_STATUS_0, 8'h00);
            wr(`OFS_LATCH_MODE_0, 8'h00);
            @(posedge core_clk);
            ev <= 5'h01 << i;
            rd(`OFS_EVENT_STATUS_0, d);
            irqIs(1'b1);
            @(posedge core_clk);
            ev <= 5'h00;
            rd(`OFS_EVENT_STATUS_0, 8'h00);
        end
        wr(`OFS_LATCH_MODE_0, 8'h88);
        pulse(5'h11);
        wr(`OFS_EVENT_STATUS_0, 8'h80);
        irqIs(1'b0);
        rd(`OFS_EVENT_STATUS_0, 8'h08);
        wr(`OFS_LATCH_MODE_0, 8'h00);
        irqIs(1'b1);
        $display("done events");
        finish_test;
    end
endmodule // tb
